//--- logic/uhlc_top.sv
// design: operational control and status registers of the host list controller
`timescale 1ns/1ps
`default_nettype none

module uhlc_top
  import uhlc_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES = FRAME_CYC
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire uhlc_apb_req_t apb_req,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  input  wire logic [31:0]   int_enable,
  input  wire logic          iso_ed_seen,
  input  wire logic          ctrl_head_req,
  input  wire logic          bulk_head_req,
  input  wire logic          ctrl_td_found,
  input  wire logic          bulk_td_found,
  input  wire logic          overrun_seen,
  input  wire logic          done_head_written,
  input  wire logic          resume_sig,
  input  wire logic          owner_change_done,
  output logic               iso_go,
  output logic               iso_stop,
  output logic               ctrl_start,
  output logic               bulk_start,
  output logic               periodic_allowed,
  output logic [1:0]         ctrl_bulk_ratio,
  output logic [1:0]         func_state,
  output logic               sof_token,
  output logic               port_reset,
  output logic               root_hub_reset,
  output logic               bus_block,
  output logic               done_head_hold,
  output logic               irq_host,
  output logic               irq_smi,
  output logic               remote_wakeup
);

  localparam int unsigned FW = $clog2(FRAME_CYCLES + 1);

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  // mode control state
  uhlc_state_t fs_q, fs_d;
  logic [1:0]  ratio_q;
  logic        ple_q, ie_q, cle_q, ble_q, ir_q, rwc_q, rwe_q;
  // command state
  logic        hcr_q, hcr_d;
  logic [3:0]  srst_cnt_q;
  logic [1:0]  filled_q;
  wire  [1:0]  filled_d;
  logic        ocr_q;
  logic [1:0]  soc_q;
  // event status: {oc, rd, sf, wdh, so}
  logic [4:0]  ev_q, ev_d;
  // frame timing
  logic [FW-1:0] fcnt_q;
  logic          ple_fr_q, ie_fr_q;
  logic [1:0]    list_fr_q;
  logic          resume_q;
  logic          pready_q, pslverr_q;
  logic [31:0]   prdata_q;
  logic          iso_go_q, iso_stop_q, sof_q, port_reset_q, rh_reset_q, block_q;
  logic [1:0]    start_q;
  logic          hold_q, irq_host_q, irq_smi_q, wake_q;

  // bus decode
  wire acc_req   = apb_req.psel & apb_req.penable;
  wire acc_done  = acc_req & pready_q;
  wire hit_mc    = addr_hit(apb_req.paddr, OFF_MODE_CONTROL);
  wire hit_cs    = addr_hit(apb_req.paddr, OFF_COMMAND_STATUS);
  wire hit_es    = addr_hit(apb_req.paddr, OFF_EVENT_STATUS);
  wire hit_any   = hit_mc | hit_cs | hit_es;
  wire bad_strb  = apb_req.pwrite & (apb_req.pstrb != STRB_FULL);
  wire acc_err   = ~hit_any | bad_strb;
  wire wr_ok     = acc_done & apb_req.pwrite & ~acc_err;
  wire wr_mc     = wr_ok & hit_mc;
  wire wr_cs     = wr_ok & hit_cs;
  wire wr_es     = wr_ok & hit_es;
  wire [31:0] wd = apb_req.pwdata;

  wire srst_go   = wr_cs & wd[CS_HCR] & ~hcr_q;
  wire srst_end  = hcr_q & (srst_cnt_q == SRST_HOLD_CYC - 4'h1);
  wire resume_rise = resume_sig & ~resume_q;
  wire in_oper   = fs_q == UHLC_STATE_OPERATIONAL;
  wire sof_fire  = in_oper & (fcnt_q == FW'(FRAME_CYCLES - 1));
  wire [1:0] list_en   = {ble_q, cle_q};
  wire [1:0] head_req  = {bulk_head_req, ctrl_head_req};
  wire [1:0] td_found  = {bulk_td_found, ctrl_td_found};
  wire [1:0] list_ok   = list_en & list_fr_q;
  wire       ocr_set   = wr_cs & wd[CS_OCR] & ~ocr_q;
  wire [4:0] ev_set    = {ocr_set, resume_rise, sof_fire, done_head_written, overrun_seen};
  wire [4:0] ev_clr    = {5{wr_es}} & {wd[ES_OC], wd[ES_RD], wd[ES_SF], wd[ES_WDH], wd[ES_SO]};
  wire [31:0] mc_word  = {21'h0, rwe_q, rwc_q, ir_q, fs_q, ble_q, cle_q, ie_q, ple_q, ratio_q};
  wire [31:0] cs_word  = {14'h0, soc_q, 12'h0, ocr_q, filled_q, hcr_q};
  wire [31:0] es_word  = {1'b0, ev_q[4], 26'h0, ev_q[3:0]};
  wire [31:0] rd_word  = hit_mc ? mc_word : hit_cs ? cs_word : hit_es ? es_word : REG_RESET;
  wire        irq_pend = int_enable[IE_MIE] & (|(es_word[30:0] & int_enable[30:0]));

  // functional state: software write, software reset, or suspend-to-resume only
  always_comb begin
    fs_d = fs_q;
    if (srst_go) begin
      fs_d = UHLC_STATE_SUSPEND;
    end else if (wr_mc) begin
      fs_d = uhlc_state_t'(wd[MC_FS_LSB +: 2]);
    end else if ((fs_q == UHLC_STATE_SUSPEND) && resume_rise) begin
      fs_d = UHLC_STATE_RESUME;
    end
  end

  always_comb begin
    hcr_d = hcr_q;
    if (srst_go) begin
      hcr_d = 1'b1;
    end else if (srst_end) begin
      hcr_d = 1'b0;
    end
  end

  // sticky events: set wins over clear, hardware never clears
  assign ev_d = srst_go ? 5'h00 : ((ev_q & ~ev_clr) | ev_set);

  // filled bits: write-one sets, descriptor found sets, accepted head check clears
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_list
      wire set_i = (wr_cs & wd[CS_CLF + gi]) | td_found[gi];
      wire clr_i = head_req[gi] & filled_q[gi] & list_ok[gi];
      assign filled_d[gi] = srst_go ? 1'b0 : (set_i | (filled_q[gi] & ~clr_i));
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fs_q    <= UHLC_STATE_RESET;
      ratio_q <= 2'b00;
      {ple_q, ie_q, cle_q, ble_q, rwe_q} <= 5'h00;
      ir_q    <= 1'b0;
      rwc_q   <= 1'b0;
    end else begin
      fs_q <= fs_d;
      if (srst_go) begin
        ratio_q <= 2'b00;
        {ple_q, ie_q, cle_q, ble_q, rwe_q} <= 5'h00;
      end else if (wr_mc) begin
        ratio_q <= wd[MC_RATIO_LSB +: 2];
        ple_q   <= wd[MC_PLE];
        ie_q    <= wd[MC_IE];
        cle_q   <= wd[MC_CLE];
        ble_q   <= wd[MC_BLE];
        ir_q    <= wd[MC_IR];
        rwc_q   <= wd[MC_RWC];
        rwe_q   <= wd[MC_RWE];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hcr_q      <= 1'b0;
      srst_cnt_q <= 4'h0;
      filled_q   <= 2'b00;
      ocr_q      <= 1'b0;
      soc_q      <= 2'b00;
      ev_q       <= 5'h00;
    end else begin
      hcr_q      <= hcr_d;
      srst_cnt_q <= hcr_q ? srst_cnt_q + 4'h1 : 4'h0;
      filled_q   <= filled_d;
      if (srst_go) begin
        ocr_q <= 1'b0;
        soc_q <= 2'b00;
      end else begin
        ocr_q <= (wr_cs & wd[CS_OCR]) | (ocr_q & ~owner_change_done);
        soc_q <= overrun_seen ? soc_q + 2'b01 : soc_q;
      end
      ev_q <= ev_d;
    end
  end

  // frame timer and per-frame latch of list enables
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fcnt_q    <= '0;
      ple_fr_q  <= 1'b0;
      ie_fr_q   <= 1'b0;
      list_fr_q <= 2'b00;
      resume_q  <= 1'b0;
    end else begin
      resume_q <= resume_sig;
      if (!in_oper || sof_fire) begin
        fcnt_q <= '0;
      end else begin
        fcnt_q <= fcnt_q + FW'(1);
      end
      if (sof_fire) begin
        ple_fr_q  <= ple_q;
        ie_fr_q   <= ie_q;
        list_fr_q <= list_en;
      end
    end
  end

  // bus slave: one wait state, answer in the second access cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= REG_RESET;
    end else begin
      pready_q  <= acc_req & ~pready_q;
      pslverr_q <= acc_req & ~pready_q & acc_err;
      prdata_q  <= (acc_req & ~pready_q & ~apb_req.pwrite) ? rd_word : REG_RESET;
    end
  end

  // outputs toward the list walker, ports and system
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      iso_go_q     <= 1'b0;
      iso_stop_q   <= 1'b0;
      start_q      <= 2'b00;
      sof_q        <= 1'b0;
      port_reset_q <= 1'b1;
      rh_reset_q   <= 1'b1;
      block_q      <= 1'b0;
      hold_q       <= 1'b0;
      irq_host_q   <= 1'b0;
      irq_smi_q    <= 1'b0;
      wake_q       <= 1'b0;
    end else begin
      iso_go_q     <= iso_ed_seen & ie_q & ie_fr_q;
      iso_stop_q   <= iso_ed_seen & ~(ie_q & ie_fr_q);
      start_q      <= head_req & filled_q & list_ok;
      sof_q        <= sof_fire;
      port_reset_q <= fs_d == UHLC_STATE_RESET;
      rh_reset_q   <= 1'b0;
      block_q      <= hcr_d;
      hold_q       <= ev_d[ES_WDH];
      irq_host_q   <= irq_pend & ~ir_q;
      irq_smi_q    <= irq_pend & ir_q;
      wake_q       <= rwe_q & ev_q[ES_RD];
    end
  end

  assign pready           = pready_q;
  assign prdata           = prdata_q;
  assign pslverr          = pslverr_q;
  assign iso_go           = iso_go_q;
  assign iso_stop         = iso_stop_q;
  assign ctrl_start       = start_q[0];
  assign bulk_start       = start_q[1];
  assign periodic_allowed = ple_fr_q;
  assign ctrl_bulk_ratio  = ratio_q;
  assign func_state       = fs_q;
  assign sof_token        = sof_q;
  assign port_reset       = port_reset_q;
  assign root_hub_reset   = rh_reset_q;
  assign bus_block        = block_q;
  assign done_head_hold   = hold_q;
  assign irq_host         = irq_host_q;
  assign irq_smi          = irq_smi_q;
  assign remote_wakeup    = wake_q;

  chk_iso_stop_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    iso_ed_seen && !ie_q |=> iso_stop_q && !iso_go_q)
    else $error("iso descriptor not abandoned while disabled");

  chk_ctrl_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctrl_start |-> $past(cle_q) && $past(filled_q[0]))
    else $error("control list started while disabled or empty");

  chk_bulk_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bulk_start |-> $past(ble_q) && $past(filled_q[1]))
    else $error("bulk list started while disabled or empty");

  chk_sof_spacing: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sof_fire |-> in_oper && $past(in_oper) ##1 sof_token && fcnt_q == '0)
    else $error("start of frame out of step with frame timer");

  chk_resume_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !$past(wr_mc) && !$past(srst_go) && fs_q != $past(fs_q)
      |-> $past(fs_q) == UHLC_STATE_SUSPEND && fs_q == UHLC_STATE_RESUME)
    else $error("illegal hardware state change");

  chk_swreset_state: assert property (@(posedge clk_sys) disable iff (!rst_n)
    srst_go |=> fs_q == UHLC_STATE_SUSPEND && ir_q == $past(ir_q) && rwc_q == $past(rwc_q))
    else $error("software reset state or kept bits wrong");

  chk_swreset_done: assert property (@(posedge clk_sys) disable iff (!rst_n)
    srst_go |=> bus_block ##[8:9] !hcr_q)
    else $error("software reset not finished in time");

  chk_irq_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (irq_host || irq_smi) |-> $past(irq_pend) && irq_smi == $past(ir_q))
    else $error("interrupt routed to wrong line");

  chk_overrun_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
    overrun_seen && !srst_go |=> soc_q == 2'($past(soc_q) + 2'b01) && ev_q[ES_SO])
    else $error("overrun counter or status not updated");

  chk_status_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ev_q[ES_WDH] && !ev_clr[ES_WDH] && !srst_go |=> ev_q[ES_WDH] && done_head_hold)
    else $error("done head status lost without a clear");

  chk_port_reset_state: assert property (@(posedge clk_sys) disable iff (!rst_n)
    port_reset == (fs_q == UHLC_STATE_RESET))
    else $error("port reset out of step with functional state");

  chk_sof_status: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sof_fire && !srst_go |=> sof_token && ev_q[ES_SF])
    else $error("start of frame status not set with token");

endmodule : uhlc_top

`default_nettype wire

//--- inc/uhlc_pkg.sv
// package: register map, field layout, states and timing of the host list control block
package uhlc_pkg;

  localparam logic [11:0] OFF_MODE_CONTROL   = 12'h504;
  localparam logic [11:0] OFF_COMMAND_STATUS = 12'h508;
  localparam logic [11:0] OFF_EVENT_STATUS   = 12'h50c;

  // host_mode_control fields
  localparam int unsigned MC_RATIO_LSB = 0;
  localparam int unsigned MC_PLE       = 2;
  localparam int unsigned MC_IE        = 3;
  localparam int unsigned MC_CLE       = 4;
  localparam int unsigned MC_BLE       = 5;
  localparam int unsigned MC_FS_LSB    = 6;
  localparam int unsigned MC_IR        = 8;
  localparam int unsigned MC_RWC       = 9;
  localparam int unsigned MC_RWE       = 10;

  // host_command_status fields
  localparam int unsigned CS_HCR     = 0;
  localparam int unsigned CS_CLF     = 1;
  localparam int unsigned CS_BLF     = 2;
  localparam int unsigned CS_OCR     = 3;
  localparam int unsigned CS_SOC_LSB = 16;

  // host_event_status fields
  localparam int unsigned ES_SO = 0;
  localparam int unsigned ES_WDH = 1;
  localparam int unsigned ES_SF = 2;
  localparam int unsigned ES_RD = 3;
  localparam int unsigned ES_OC = 30;
  localparam int unsigned IE_MIE = 31;

  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [3:0]  STRB_FULL = 4'hf;

  // timing
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned FRAME_TIME_NS  = 1000000;
  localparam int unsigned FRAME_CYC      = FRAME_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned SRST_LIMIT_NS  = 10000000;
  localparam int unsigned SRST_LIMIT_CYC = SRST_LIMIT_NS / CLK_PERIOD_NS;
  localparam logic [3:0]  SRST_HOLD_CYC  = 4'h8;

  typedef enum logic [1:0] {
    UHLC_STATE_RESET       = 2'b00,
    UHLC_STATE_RESUME      = 2'b01,
    UHLC_STATE_OPERATIONAL = 2'b10,
    UHLC_STATE_SUSPEND     = 2'b11
  } uhlc_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } uhlc_apb_req_t;

endpackage : uhlc_pkg

//--- testbench/uhlc_port_model.sv
// far-side model: downstream device that raises resume signalling on request
`timescale 1ns/1ps
`default_nettype none
module uhlc_port_model (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic port_reset,
  input  wire logic wake_req,
  output logic      resume_sig
);
  // a port held in reset signalling cannot answer with resume
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      resume_sig <= 1'b0;
    end else begin
      resume_sig <= wake_req & ~port_reset;
    end
  end
endmodule // uhlc_port_model
`default_nettype wire

//--- testbench/uhlc_top_tb_top.sv
// testbench: register and walker-strobe scenarios for the host list control block
`timescale 1ns/1ps
`default_nettype none
module uhlc_top_tb_top;
  import uhlc_pkg::*;
  localparam int F = 64;
  logic clk_sys, rst_n, pready, pslverr, wake, resume_sig, slv;
  logic iso_go, iso_stop, ctrl_start, bulk_start, periodic_allowed, sof_token;
  logic port_reset, root_hub_reset, bus_block, done_head_hold, irq_host, irq_smi, remote_wakeup;
  logic [1:0] ctrl_bulk_ratio, func_state;
  logic [31:0] prdata, int_enable, rv;
  logic [7:0] str;
  uhlc_apb_req_t req;
  int err_total, compares, n;

  uhlc_top #(.FRAME_CYCLES(F)) uhlc_top_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .apb_req(req), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .int_enable(int_enable), .iso_ed_seen(str[0]),
    .ctrl_head_req(str[1]), .bulk_head_req(str[2]), .ctrl_td_found(str[3]),
    .bulk_td_found(str[4]), .overrun_seen(str[5]), .done_head_written(str[6]),
    .resume_sig(resume_sig), .owner_change_done(str[7]), .iso_go(iso_go),
    .iso_stop(iso_stop), .ctrl_start(ctrl_start), .bulk_start(bulk_start),
    .periodic_allowed(periodic_allowed), .ctrl_bulk_ratio(ctrl_bulk_ratio),
    .func_state(func_state), .sof_token(sof_token), .port_reset(port_reset),
    .root_hub_reset(root_hub_reset), .bus_block(bus_block),
    .done_head_hold(done_head_hold), .irq_host(irq_host), .irq_smi(irq_smi),
    .remote_wakeup(remote_wakeup));
  uhlc_port_model uhlc_port_model_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .port_reset(port_reset), .wake_req(wake), .resume_sig(resume_sig));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic finish_test;
    if (err_total == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk_sys);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: s};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    // the wait for the slave's answer ends when pready is high; it has no cycle limit, so only the watchdog ends it if pready never rises
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rv = prdata;
    slv = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, STRB_FULL);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rv, exp);
  endtask

  // one-cycle strobe; returns at the edge where the registered answer is visible
  task automatic pulse(input logic [7:0] m);
    @(posedge clk_sys);
    str <= m;
    @(posedge clk_sys);
    str <= 8'h00;
    @(posedge clk_sys);
  endtask

  task automatic w_sof;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (sof_token !== 1'b1 && n < 1000);
  endtask

  initial begin
    repeat (50000) @(posedge clk_sys);
    err_total++;
    finish_test;
  end

  initial begin
    rst_n = 1'b0; req = '0; str = 8'h00; int_enable = 32'h0; wake = 1'b0;
    err_total = 0; compares = 0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk(32'({root_hub_reset, port_reset}), 32'h3);
    chk(32'(func_state), 32'h0);
    rd(OFF_MODE_CONTROL, 32'h0);
    chk(32'(root_hub_reset), 32'h0);
    rd(OFF_COMMAND_STATUS, 32'h0);
    rd(OFF_EVENT_STATUS, 32'h0);
    rd(12'h500, 32'h0);
    chk(32'(slv), 32'h1);
    apb(1'b1, OFF_MODE_CONTROL, 32'h0000_07b4, 4'h3);
    chk(32'(slv), 32'h1);
    rd(OFF_MODE_CONTROL, 32'h0);
    wr(OFF_MODE_CONTROL, 32'h0000_00b4);
    w_sof;
    chk(32'(n >= F && n <= F + 3), 32'h1);
    chk(32'(func_state), 32'h2);
    chk(32'(periodic_allowed), 32'h1);
    w_sof;
    chk(32'(n), 32'(F));
    rd(OFF_EVENT_STATUS, 32'h4);
    wr(OFF_EVENT_STATUS, 32'h4);
    rd(OFF_EVENT_STATUS, 32'h0);
    pulse(8'h01);
    chk(32'({iso_go, iso_stop}), 32'h1);
    wr(OFF_MODE_CONTROL, 32'h0000_00bc);
    pulse(8'h01);
    chk(32'({iso_go, iso_stop}), 32'h1);
    w_sof;
    pulse(8'h01);
    chk(32'({iso_go, iso_stop}), 32'h2);
    wr(OFF_COMMAND_STATUS, 32'h6);
    wr(OFF_COMMAND_STATUS, 32'h0);
    rd(OFF_COMMAND_STATUS, 32'h6);
    for (int i = 0; i < 2; i++) begin
      pulse(8'h02 << i);
      chk(32'({bulk_start, ctrl_start}), 32'h1 << i);
      pulse(8'h02 << i);
      chk(32'({bulk_start, ctrl_start}), 32'h0);
      rd(OFF_COMMAND_STATUS, i == 0 ? 32'h4 : 32'h2);
      pulse(8'h08 << i);
    end
    rd(OFF_COMMAND_STATUS, 32'h6);
    // with both lists disabled, head requests start neither list
    wr(OFF_MODE_CONTROL, 32'h0000_008c);
    w_sof;
    pulse(8'h06);
    chk(32'({bulk_start, ctrl_start}), 32'h0);
    repeat (5) pulse(8'h20);
    rd(OFF_COMMAND_STATUS, 32'h0001_0006);
    chk(32'(rv[ES_SO]), 32'h0);
    apb(1'b0, OFF_EVENT_STATUS, 32'h0, 4'h0);
    chk(32'(rv[ES_SO]), 32'h1);
    int_enable <= 32'h8000_0002;
    pulse(8'h40);
    @(posedge clk_sys);
    chk(32'(done_head_hold), 32'h1);
    chk(32'({irq_smi, irq_host}), 32'h1);
    wr(OFF_MODE_CONTROL, 32'h0000_018c);
    repeat (2) @(posedge clk_sys);
    chk(32'({irq_smi, irq_host}), 32'h2);
    wr(OFF_EVENT_STATUS, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk(32'({done_head_hold, irq_smi, irq_host}), 32'h0);
    wr(OFF_COMMAND_STATUS, 32'h8);
    apb(1'b0, OFF_EVENT_STATUS, 32'h0, 4'h0);
    chk(32'(rv[ES_OC]), 32'h1);
    pulse(8'h80);
    apb(1'b0, OFF_COMMAND_STATUS, 32'h0, 4'h0);
    chk(32'(rv[CS_OCR]), 32'h0);
    wr(OFF_MODE_CONTROL, 32'h0000_07cf);
    @(posedge clk_sys);
    chk(32'({ctrl_bulk_ratio, func_state}), 32'hf);
    wake <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (func_state !== 2'b01 && n < 100);
    chk(32'(func_state), 32'h1);
    @(posedge clk_sys);
    chk(32'(remote_wakeup), 32'h1);
    chk(32'({irq_smi, irq_host}), 32'h0);
    wake <= 1'b0;
    wr(OFF_COMMAND_STATUS, 32'h1);
    @(posedge clk_sys);
    chk(32'(bus_block), 32'h1);
    n = 0;
    while (bus_block !== 1'b0 && n < 1000) begin
      @(posedge clk_sys);
      n++;
    end
    rd(OFF_MODE_CONTROL, 32'h0000_03c0);
    rd(OFF_COMMAND_STATUS, 32'h0);
    rd(OFF_EVENT_STATUS, 32'h0);
    chk(32'({root_hub_reset, port_reset}), 32'h0);
    chk(32'(ctrl_bulk_ratio), 32'h0);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk(32'({root_hub_reset, port_reset}), 32'h3);
    rd(OFF_MODE_CONTROL, 32'h0);
    finish_test;
  end
endmodule // uhlc_top_tb_top
`default_nettype wire
